// ---- inc/nisc_defines.vh ----
// Purpose: constants for the node init state control block
// Assumes: 10 MHz clock
// Notes:   command and message codes are local encodings
`ifndef NISC_DEFINES_VH
`define NISC_DEFINES_VH
`define NISC_CLK_HZ        32'h0098_9680
`define NISC_CMD_NONE      4'h0
`define NISC_CMD_RESET     4'h1
`define NISC_CMD_QCANCEL   4'h2
`define NISC_CMD_DOMAIN    4'h3
`define NISC_CMD_SETMODE   4'h4
`define NISC_CMD_MSG       4'h5
`define NISC_CMD_HWPROPS   4'h6
`define NISC_CMD_COMMPAR   4'h7
`define NISC_CMD_SVCPIN    4'h8
`define NISC_RSP_OK        2'h1
`define NISC_RSP_FAIL      2'h2
`define NISC_RSP_REJECT    2'h3
`define NISC_NV_CONFIGURED 2'h0
`define NISC_NV_DOM_LO     2'h1
`define NISC_NV_DOM_HI     2'h2
`define NISC_RST_CYCLES    8'h10
`endif

// ---- src/nisc_nvmem.v ----
// Purpose: small nonvolatile store for configured flag and domains
// Assumes: contents held across resets; reset does not touch it
// Notes:   read data is registered
`timescale 1ns/100ps
`default_nettype none
module nisc_nvmem (
  input  wire       clk_in,
  input  wire       we_in,
  input  wire [1:0] waddr_in,
  input  wire       wdata_in,
  input  wire [1:0] raddr_in,
  output reg        rdata_out
);
  reg mem [0:3];
  always @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end
endmodule
`default_nettype wire

// ---- src/nisc_top.v ----
// Purpose: init and installation state control for a network node
// Assumes: one command per CMD_VALID_IN pulse; inputs synchronous
// Notes:   nonvolatile state reloaded from the store after reset
// Behaviour
// - reset enters quiesced unless network enable is set; configured state reloaded from store, cleared if stored domain is zero
// - quiesced: network management messages from network are ignored
// - unconfigured: application messages from network are not delivered
// - configured only after a domain assigned and mode set configured
// - configure may come from host or from the network
// - configured state and domains kept in nonvolatile store
// - with network disable, every reset re-enters quiesced
// - quiesced host message: acked fails, unacked succeeds, none sent
// - normal unconfigured host message: success, not sent
// - reset command resets then sends reset notification uplink
// - first uplink message after power-up is reset notification
// - host quiesce cancel command leaves quiesced; from network it is ignored
// - hardware properties rejected unless clock rate equals 10 MHz
// - communication parameters rejected if channel mismatches transceiver
// - service-pin install only if quiesce cancelled or network enable
`timescale 1ns/100ps
`default_nettype none
`include "nisc_defines.vh"
module nisc_top (
  input  wire        CLK_IN,
  input  wire        RST_N_IN,
  input  wire        NET_ENABLE_CFG_INPUT_IN,
  input  wire        CMD_VALID_IN,
  input  wire [3:0]  CMD_CODE_IN,
  input  wire        CMD_FROM_NET_IN,
  input  wire        CMD_ACKED_IN,
  input  wire        CMD_APP_IN,
  input  wire [1:0]  CMD_DOMAIN_IN,
  input  wire        CMD_MODE_CFG_IN,
  input  wire [31:0] CMD_CLK_HZ_IN,
  input  wire [7:0]  CMD_CHANNEL_IN,
  input  wire [7:0]  XCVR_CHANNEL_IN,
  output reg         RSP_VALID_OUT,
  output reg  [1:0]  RSP_CODE_OUT,
  output reg         NET_TX_OUT,
  output reg         APP_DELIVER_OUT,
  output reg         NM_DELIVER_OUT,
  output reg         UPLINK_RESET_OUT,
  output wire        QUIESCED_OUT,
  output wire        CONFIGURED_OUT,
  output wire        BUSY_OUT
);
  localparam ST_LOAD0 = 3'd0;
  localparam ST_LOAD1 = 3'd1;
  localparam ST_LOAD2 = 3'd2;
  localparam ST_LOAD3 = 3'd3;
  localparam ST_RUN   = 3'd4;
  localparam ST_SOFT  = 3'd5;
  localparam ST_NVHI  = 3'd6;

  reg  [2:0] state_reg;
  reg        quiesced_reg;
  reg        configured_reg;
  reg  [1:0] domain_reg;
  reg        notify_reg;
  reg  [7:0] cnt_reg;
  reg        nv_we;
  reg  [1:0] nv_waddr;
  reg        nv_wdata;
  reg  [1:0] nv_raddr;
  wire       nv_rdata;

  nisc_nvmem u_nv (
    .clk_in    (CLK_IN),
    .we_in     (nv_we),
    .waddr_in  (nv_waddr),
    .wdata_in  (nv_wdata),
    .raddr_in  (nv_raddr),
    .rdata_out (nv_rdata)
  );

  function [1:0] rsp_for;
    input q;
    input acked;
    begin
      if (q && acked) begin
        rsp_for = `NISC_RSP_FAIL;
      end else begin
        rsp_for = `NISC_RSP_OK;
      end
    end
  endfunction

  assign QUIESCED_OUT   = quiesced_reg;
  assign CONFIGURED_OUT = configured_reg;
  assign BUSY_OUT       = (state_reg != ST_RUN);

  always @* begin
    nv_raddr = `NISC_NV_CONFIGURED;
    case (state_reg)
      ST_LOAD0: nv_raddr = `NISC_NV_CONFIGURED;
      ST_LOAD1: nv_raddr = `NISC_NV_DOM_LO;
      ST_LOAD2: nv_raddr = `NISC_NV_DOM_HI;
      default:  nv_raddr = `NISC_NV_CONFIGURED;
    endcase
  end

  // commands are only taken in ST_RUN so busy windows drop them
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_reg        <= ST_LOAD0;
      quiesced_reg     <= 1'b1;
      configured_reg   <= 1'b0;
      domain_reg       <= 2'b00;
      notify_reg       <= 1'b1;
      cnt_reg          <= 8'h00;
      RSP_VALID_OUT    <= 1'b0;
      RSP_CODE_OUT     <= 2'b00;
      NET_TX_OUT       <= 1'b0;
      APP_DELIVER_OUT  <= 1'b0;
      NM_DELIVER_OUT   <= 1'b0;
      UPLINK_RESET_OUT <= 1'b0;
      nv_we            <= 1'b0;
      nv_waddr         <= 2'b00;
      nv_wdata         <= 1'b0;
    end else begin
      RSP_VALID_OUT    <= 1'b0;
      NET_TX_OUT       <= 1'b0;
      APP_DELIVER_OUT  <= 1'b0;
      NM_DELIVER_OUT   <= 1'b0;
      UPLINK_RESET_OUT <= 1'b0;
      nv_we            <= 1'b0;
      case (state_reg)
        ST_LOAD0: begin
          // strap caught after release, not under the async reset
          quiesced_reg <= ~NET_ENABLE_CFG_INPUT_IN;
          state_reg    <= ST_LOAD1;
        end
        ST_LOAD1: begin
          configured_reg <= nv_rdata;
          state_reg      <= ST_LOAD2;
        end
        ST_LOAD2: begin
          domain_reg[0] <= nv_rdata;
          state_reg     <= ST_LOAD3;
        end
        ST_LOAD3: begin
          domain_reg[1] <= nv_rdata;
          configured_reg <= configured_reg & (domain_reg[0] | nv_rdata);
          state_reg     <= ST_RUN;
          if (notify_reg) begin
            UPLINK_RESET_OUT <= 1'b1;
            notify_reg       <= 1'b0;
          end
        end
        ST_SOFT: begin
          if (cnt_reg == `NISC_RST_CYCLES) begin
            notify_reg <= 1'b1;
            state_reg  <= ST_LOAD0;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        ST_NVHI: begin
          // one-bit store needs a second write; costs one busy cycle
          nv_we     <= 1'b1;
          nv_waddr  <= `NISC_NV_DOM_HI;
          nv_wdata  <= domain_reg[1];
          state_reg <= ST_RUN;
        end
        ST_RUN: begin
          if (CMD_VALID_IN) begin
            case (CMD_CODE_IN)
              `NISC_CMD_RESET: begin
                cnt_reg        <= 8'h00;
                quiesced_reg   <= 1'b1;
                state_reg      <= ST_SOFT;
              end
              `NISC_CMD_QCANCEL: begin
                if (!CMD_FROM_NET_IN) begin
                  quiesced_reg <= 1'b0;
                end
              end
              `NISC_CMD_DOMAIN, `NISC_CMD_SETMODE: begin
                if (CMD_FROM_NET_IN && quiesced_reg) begin
                  RSP_VALID_OUT <= 1'b0;
                end else begin
                  RSP_VALID_OUT <= 1'b1;
                  RSP_CODE_OUT  <= `NISC_RSP_OK;
                  nv_we         <= 1'b1;
                  if (CMD_CODE_IN == `NISC_CMD_DOMAIN) begin
                    domain_reg <= CMD_DOMAIN_IN;
                    nv_waddr   <= `NISC_NV_DOM_LO;
                    state_reg  <= ST_NVHI;
                    nv_wdata   <= CMD_DOMAIN_IN[0];
                    if (CMD_DOMAIN_IN == 2'b00) begin
                      configured_reg <= 1'b0;
                    end
                  end else if (CMD_MODE_CFG_IN && domain_reg != 2'b00) begin
                    configured_reg <= 1'b1;
                    nv_waddr       <= `NISC_NV_CONFIGURED;
                    nv_wdata       <= 1'b1;
                  end else begin
                    configured_reg <= 1'b0;
                    nv_waddr       <= `NISC_NV_CONFIGURED;
                    nv_wdata       <= 1'b0;
                    RSP_CODE_OUT   <= CMD_MODE_CFG_IN ? `NISC_RSP_REJECT
                                                      : `NISC_RSP_OK;
                  end
                end
              end
              `NISC_CMD_MSG: begin
                if (CMD_FROM_NET_IN) begin
                  NM_DELIVER_OUT  <= ~CMD_APP_IN & ~quiesced_reg;
                  APP_DELIVER_OUT <= CMD_APP_IN & configured_reg
                                     & ~quiesced_reg;
                end else begin
                  RSP_VALID_OUT <= 1'b1;
                  RSP_CODE_OUT  <= rsp_for(quiesced_reg, CMD_ACKED_IN);
                  NET_TX_OUT    <= ~quiesced_reg & configured_reg;
                end
              end
              `NISC_CMD_HWPROPS: begin
                RSP_VALID_OUT <= 1'b1;
                RSP_CODE_OUT  <= (CMD_CLK_HZ_IN == `NISC_CLK_HZ)
                                 ? `NISC_RSP_OK : `NISC_RSP_REJECT;
              end
              `NISC_CMD_COMMPAR: begin
                RSP_VALID_OUT <= 1'b1;
                RSP_CODE_OUT  <= (CMD_CHANNEL_IN == XCVR_CHANNEL_IN)
                                 ? `NISC_RSP_OK : `NISC_RSP_REJECT;
              end
              `NISC_CMD_SVCPIN: begin
                RSP_VALID_OUT <= 1'b1;
                RSP_CODE_OUT  <= quiesced_reg ? `NISC_RSP_REJECT
                                              : `NISC_RSP_OK;
              end
              default: begin
                RSP_VALID_OUT <= 1'b0;
              end
            endcase
          end
        end
        default: begin
          state_reg <= ST_LOAD0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- verification/nisc_sva.sv ----
// Purpose: port checks for the init state control top
// Assumes: command taken when valid meets busy low
// Notes:   answers seen one cycle after the taking edge
`timescale 1ns/100ps
`default_nettype none
module nisc_sva (
  input wire logic        CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic        CMD_VALID_IN,
  input wire logic        CMD_FROM_NET_IN,
  input wire logic        CMD_ACKED_IN,
  input wire logic        CMD_APP_IN,
  input wire logic        CMD_MODE_CFG_IN,
  input wire logic        BUSY_OUT,
  input wire logic        RSP_VALID_OUT,
  input wire logic        NET_TX_OUT,
  input wire logic        APP_DELIVER_OUT,
  input wire logic        NM_DELIVER_OUT,
  input wire logic        UPLINK_RESET_OUT,
  input wire logic        QUIESCED_OUT,
  input wire logic        CONFIGURED_OUT,
  input wire logic [3:0]  CMD_CODE_IN,
  input wire logic [31:0] CMD_CLK_HZ_IN,
  input wire logic [1:0]  RSP_CODE_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  wire tk = CMD_VALID_IN && !BUSY_OUT;
  wire hm = tk && CMD_CODE_IN == 4'h5 && !CMD_FROM_NET_IN;
  wire nm = tk && CMD_CODE_IN == 4'h5 && CMD_FROM_NET_IN;
  wire sm = tk && CMD_CODE_IN == 4'h4 && CMD_MODE_CFG_IN;
  wire ok = RSP_VALID_OUT && RSP_CODE_OUT == 2'h1;
  wire rj = RSP_VALID_OUT && RSP_CODE_OUT == 2'h3;
  property p_fm; hm && QUIESCED_OUT |=> RSP_VALID_OUT && !NET_TX_OUT &&
    RSP_CODE_OUT == ($past(CMD_ACKED_IN) ? 2'h2 : 2'h1); endproperty
  a_fm: assert property (p_fm) else $error("flush msg");
  property p_um; hm && !QUIESCED_OUT && !CONFIGURED_OUT |=> ok &&
    !NET_TX_OUT; endproperty
  a_um: assert property (p_um) else $error("unconf msg");
  property p_nm; nm && !CMD_APP_IN && QUIESCED_OUT |=> !NM_DELIVER_OUT;
  endproperty
  a_nm: assert property (p_nm) else $error("mgmt passed");
  property p_am; nm && CMD_APP_IN && !CONFIGURED_OUT |=> !APP_DELIVER_OUT;
  endproperty
  a_am: assert property (p_am) else $error("app passed");
  // reload from the store happens while busy, so it is excluded
  property p_cf; $rose(CONFIGURED_OUT) && !$past(BUSY_OUT) |-> $past(sm);
  endproperty
  a_cf: assert property (p_cf) else $error("config cause");
  property p_qc; tk && CMD_CODE_IN == 4'h2 && !CMD_FROM_NET_IN |=>
    !QUIESCED_OUT; endproperty
  a_qc: assert property (p_qc) else $error("cancel");
  property p_hw; tk && CMD_CODE_IN == 4'h6 &&
    CMD_CLK_HZ_IN != 32'h0098_9680 |=> rj; endproperty
  a_hw: assert property (p_hw) else $error("clock rate");
  property p_up; tk && CMD_CODE_IN == 4'h1 |-> ##[18:26] UPLINK_RESET_OUT;
  endproperty
  a_up: assert property (p_up) else $error("reset note");
endmodule
`default_nettype wire

// ---- verification/nisc_host.sv ----
// Purpose: host side command driver
// Assumes: called only once the block is out of its load
// Notes:   drives on the fall, held across one rising edge
`timescale 1ns/100ps
`default_nettype none
module nisc_host (input wire clk, output reg v, output reg [3:0] c,
  output reg n, output reg a, output reg [7:0] x, output reg [31:0] hz);
  initial {v, c, n, a, x, hz} = 0;
  task go(input [3:0] cc, input nn, input aa, input [7:0] xx);
    begin
      @(negedge clk);
      {v, c, n, a, x} = {1'b1, cc, nn, aa, xx};
      @(negedge clk);
      // released data is inverted so no stale value looks valid
      {v, x} = {1'b0, ~xx};
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/node_init_state_control_test.sv ----
// Purpose: bench for the init state control top
// Assumes: store unknown until the first domain assign
// Notes:   answers read on the fall after the taking edge
`timescale 1ns/100ps
`default_nettype none
module node_init_state_control_test;
  reg         clk = 0, rst_n = 0, strap = 0;
  reg  [7:0]  xcv = 8'h5a;
  wire        v, n, a, rv, tx, ad, nd, up, qo, co, bz;
  wire [3:0]  c;
  wire [7:0]  x;
  wire [31:0] hz;
  wire [1:0]  rc;
  integer     n_fail = 0, total_checks = 0, cyc = 0, i, j, r, er, ec;
  integer     seed = 32'hddc167ce, q = 1, cf = -1, dm = 0;
  // first command in the top word; nibbles: code, {net, acked}, data
  localparam [319:0] SEQ = {16'h5100, 16'h5000, 16'h5200, 16'h2200,
    16'h4201, 16'h3000, 16'h5100, 16'h2000, 16'h5100, 16'h4001, 16'h5300,
    16'h5200, 16'h3201, 16'h4201, 16'h5300, 16'h5100, 16'h8000, 16'h1000,
    16'h8000, 16'h5100};
  nisc_host h (.clk(clk), .v(v), .c(c), .n(n), .a(a), .x(x), .hz(hz));
  nisc_top uut (.CLK_IN(clk), .RST_N_IN(rst_n),
    .NET_ENABLE_CFG_INPUT_IN(strap), .CMD_VALID_IN(v), .CMD_CODE_IN(c),
    .CMD_FROM_NET_IN(n), .CMD_ACKED_IN(a), .CMD_APP_IN(a),
    .CMD_DOMAIN_IN(x[1:0]), .CMD_MODE_CFG_IN(x[0]), .CMD_CLK_HZ_IN(hz),
    .CMD_CHANNEL_IN(x), .XCVR_CHANNEL_IN(xcv), .RSP_VALID_OUT(rv),
    .RSP_CODE_OUT(rc), .NET_TX_OUT(tx), .APP_DELIVER_OUT(ad),
    .NM_DELIVER_OUT(nd), .UPLINK_RESET_OUT(up), .QUIESCED_OUT(qo),
    .CONFIGURED_OUT(co), .BUSY_OUT(bz));
  initial forever #50 clk = ~clk;
  always @(posedge clk) if (++cyc == 3000) begin n_fail++; wrap_up; end
  task chk(input [15:0] nm, input [31:0] s, input [31:0] e);
    begin
      total_checks++;
      if (s !== e) n_fail++;
      if (s !== e) $display("BAD %s exp %0h got %0h", nm, e, s);
    end
  endtask
  task wup;
    begin
      for (j = 0; j < 40 && up !== 1; j++) @(negedge clk);
      chk("up", up, 1);
      chk("bz", bz, 0);
      q = !strap;
    end
  endtask
  task rst(input s);
    begin
      {strap, rst_n} = {s, 1'b0};
      repeat (3) @(negedge clk);
      rst_n = 1;
      wup;
      chk("qo", qo, q);
      if (cf >= 0) chk("cf", co, cf);
    end
  endtask
  task run(input [15:0] w);
    reg [3:0] cc;
    reg       nn, aa, ok;
    reg [7:0] xx;
    begin
      {cc, nn, aa, xx} = {w[15:12], w[9:0]};
      h.go(cc, nn, aa, xx);
      ok = !(nn && q);
      er = ((cc == 3 || cc == 4) && ok) || cc > 5 || (cc == 5 && !nn);
      ec = (cc == 4 && xx[0] && dm == 0) || (cc == 7 && xx != xcv) ||
        (cc == 6 && hz != 32'h0098_9680) ? 3 : (cc == 5 && q && aa ? 2 : 1);
      if (cc == 1) wup;
      if (cc == 2 && !nn) q = 0;
      if (cc == 3 && ok) dm = xx[1:0];
      if (cc == 3 && ok && dm == 0) cf = 0;
      if (cc == 4 && ok && ec == 1) cf = xx[0];
      chk("rv", rv, er);
      if (cc != 1) chk("up", up, 0);
      if (er == 1 && cc != 8) chk("rc", rc, ec);
      if (cc == 8) chk("sv", rc === 2'h1, !q);
      chk("tx", tx, cc == 5 && !nn && !q && cf == 1);
      chk("nd", nd, cc == 5 && nn && !aa && !q);
      chk("ad", ad, cc == 5 && nn && aa && !q && cf == 1);
      chk("qo", qo, q);
      if (cf >= 0) chk("cf", co, cf);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    rst(0);
    for (i = 19; i >= 0; i--) run(SEQ[i*16 +: 16]);
    rst(1);
    for (i = 0; i < 6; i++) begin
      r = $random(seed);
      h.hz = i ? $random(seed) : 32'h0098_9680;
      run(16'h6000);
      run({8'h70, i ? r[7:0] : xcv});
    end
    run(16'h5100);
    wrap_up;
  end
endmodule
bind nisc_top nisc_sva chk_i (
  .CLK_IN           (CLK_IN),
  .RST_N_IN         (RST_N_IN),
  .CMD_VALID_IN     (CMD_VALID_IN),
  .CMD_FROM_NET_IN  (CMD_FROM_NET_IN),
  .CMD_ACKED_IN     (CMD_ACKED_IN),
  .CMD_APP_IN       (CMD_APP_IN),
  .CMD_MODE_CFG_IN  (CMD_MODE_CFG_IN),
  .BUSY_OUT         (BUSY_OUT),
  .RSP_VALID_OUT    (RSP_VALID_OUT),
  .NET_TX_OUT       (NET_TX_OUT),
  .APP_DELIVER_OUT  (APP_DELIVER_OUT),
  .NM_DELIVER_OUT   (NM_DELIVER_OUT),
  .UPLINK_RESET_OUT (UPLINK_RESET_OUT),
  .QUIESCED_OUT     (QUIESCED_OUT),
  .CONFIGURED_OUT   (CONFIGURED_OUT),
  .CMD_CODE_IN      (CMD_CODE_IN),
  .CMD_CLK_HZ_IN    (CMD_CLK_HZ_IN),
  .RSP_CODE_OUT     (RSP_CODE_OUT)
);
`default_nettype wire
